// ===== src/cch_i2c_target.sv
module cch_i2c_target (
    input  wire logic       core_clk, // core clock
    input  wire logic       reset,    // async reset, active high
    input  wire logic [6:0] own_addr, // address answered
    input  wire logic       scl_in,   // scl pin level
    input  wire logic       sda_in,   // sda pin level
    input  wire logic [7:0] tx_data,  // byte returned on reads
    output logic            sda_oe,   // pull sda low when high
    output logic            rd_done   // pulse: a byte was read out
);
    import cch_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_TX, ST_TX_ACK, ST_RX, ST_RX_ACK
    } cch_i2c_state_t;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic       scl_prev_ff;
    logic       sda_prev_ff;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_in};
            sda_sync_ff <= {sda_sync_ff[0], sda_in};
            scl_prev_ff <= scl_sync_ff[1];
            sda_prev_ff <= sda_sync_ff[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_s     = scl_sync_ff[1];
    assign sda_s     = sda_sync_ff[1];
    assign scl_rise  = scl_s & ~scl_prev_ff;
    assign scl_fall  = ~scl_s & scl_prev_ff;
    assign bus_start = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
    assign bus_stop  = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    cch_i2c_state_t state_ff;
    logic [3:0]     bit_cnt_ff;
    logic [7:0]     shift_ff;
    logic           rw_ff;
    logic           mack_ff;

    // data changes only after scl falls, so the controller sees it stable high
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_ff   <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 8'h00;
            rw_ff      <= 1'b0;
            mack_ff    <= 1'b0;
            sda_oe     <= 1'b0;
            rd_done    <= 1'b0;
        end else begin
            rd_done <= 1'b0;
            if (bus_stop) begin
                state_ff <= ST_IDLE;
                sda_oe   <= 1'b0;
            end else if (bus_start) begin
                state_ff   <= ST_ADDR;
                bit_cnt_ff <= 4'h0;
                sda_oe     <= 1'b0;
            end else if (scl_rise) begin
                unique case (state_ff)
                    ST_ADDR, ST_RX: begin
                        shift_ff   <= {shift_ff[6:0], sda_s};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    ST_TX: begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    ST_TX_ACK: begin
                        mack_ff <= ~sda_s;
                        rd_done <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                unique case (state_ff)
                    ST_ADDR: begin
                        if (bit_cnt_ff == I2C_BITS_PER_BYTE) begin
                            if (shift_ff[7:1] == own_addr) begin // RQ7
                                state_ff <= ST_ADDR_ACK;
                                rw_ff    <= shift_ff[0];
                                sda_oe   <= 1'b1;
                            end else begin
                                state_ff <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK, ST_RX_ACK: begin
                        bit_cnt_ff <= 4'h0;
                        if (state_ff == ST_ADDR_ACK && rw_ff) begin
                            shift_ff <= tx_data; // RQ8
                            sda_oe   <= ~tx_data[7];
                            state_ff <= ST_TX;
                        end else begin
                            sda_oe   <= 1'b0;
                            state_ff <= ST_RX;
                        end
                    end
                    ST_TX: begin
                        if (bit_cnt_ff == I2C_BITS_PER_BYTE) begin
                            sda_oe   <= 1'b0;
                            state_ff <= ST_TX_ACK;
                        end else begin
                            shift_ff <= {shift_ff[6:0], 1'b0};
                            sda_oe   <= ~shift_ff[6];
                        end
                    end
                    ST_TX_ACK: begin
                        bit_cnt_ff <= 4'h0;
                        if (mack_ff) begin
                            shift_ff <= tx_data;
                            sda_oe   <= ~tx_data[7];
                            state_ff <= ST_TX;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                    ST_RX: begin
                        // written bytes are acknowledged and dropped
                        if (bit_cnt_ff == I2C_BITS_PER_BYTE) begin
                            sda_oe   <= 1'b1;
                            state_ff <= ST_RX_ACK;
                        end
                    end
                    ST_IDLE: begin
                    end
                endcase
            end
        end
    end

endmodule

// ===== src/cch_pkg.sv
package cch_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CORE_CLK_HZ      = 40_000_000;
    localparam int unsigned RELEASE_DELAY_US = 100;
    // least time in whole cycles, MHz figure truncated, never below 1
    localparam int unsigned RELEASE_CYC      =
        (RELEASE_DELAY_US * (CORE_CLK_HZ / 1_000_000) + 0) < 1 ? 1 :
        (RELEASE_DELAY_US * (CORE_CLK_HZ / 1_000_000));
    localparam int unsigned RELEASE_CNT_W    = $clog2(RELEASE_CYC + 1);

    // ------------------------------------------------------------
    // status target port
    // ------------------------------------------------------------
    localparam logic [6:0] STATUS_TARGET_ADDR = 7'h38;
    localparam logic [3:0] I2C_BITS_PER_BYTE  = 4'h8;
    localparam logic [3:0] STATUS_PAD         = 4'h0;

    // connection state reported by the port policy logic
    typedef struct packed {
        logic highspeed_link_mode_event; // high-speed link alternate mode active
        logic dp_mode_event;             // display mode selected
        logic orientation_flipped;       // cable plugged flipped
        logic attached;                  // connection present
    } cch_port_status_t;

    localparam cch_port_status_t STATUS_RESET = '0;

    // sideband mux control lines
    typedef struct packed {
        logic aux_orientation_select;
        logic lowspeed_orientation_select;
        logic aux_path_enable;
        logic lowspeed_path_enable;
    } cch_mux_ctrl_t;

    localparam cch_mux_ctrl_t MUX_RESET = '0;

endpackage

// ===== src/cch_handoff.sv
// Behaviour
// RQ1 - own configuration is read from shared flash before companion gets the flash
// RQ2 - companion reset stays asserted until configuration load completes
// RQ3 - output 0 only ever carries the companion master reset
// RQ4 - reset release waits at least 100 us after companion supply valid
// RQ5 - reset output ANDed with companion 3.3 V supply good
// RQ6 - host controller may hold reset until system boot completes
// RQ7 - status target port answers 7-bit address 0x38
// RQ8 - companion reads current connection status over the target port
// RQ9 - connection changes raise a dedicated interrupt; companion then reads status
// RQ10 - both orientation selects follow the cable orientation event
// RQ11 - aux enable from display mode, low-speed enable from high-speed mode
// RQ12 - interrupt stays asserted until the companion reads the status
module cch_handoff
    import cch_pkg::*;
(
    input  wire logic                      core_clk,             // 40 MHz core clock
    input  wire logic                      reset,                // async reset, active high
    input  wire logic                      cfg_load_done,        // own config read from flash
    input  wire logic                      host_release_mode,    // host gates release on boot
    input  wire logic                      host_boot_done,       // system boot completed
    input  wire logic                      companion_supply_3v3, // companion rail good pin
    input  wire cch_pkg::cch_port_status_t port_status,          // port policy events
    input  wire logic                      status_scl_in,        // target port scl level
    input  wire logic                      status_sda_in,        // target port sda level
    output logic                           status_sda_out,       // sda drive level
    output logic                           status_sda_oe,        // sda pulled low when high
    output logic                           companion_reset_n,    // output 0, master reset
    output logic                           flash_companion_grant,// companion may use flash
    output logic                           status_irq,           // connection change pending
    output cch_pkg::cch_mux_ctrl_t         mux_ctrl              // sideband mux controls
);
    import cch_pkg::*;

    // ------------------------------------------------------------
    // supply good synchroniser and settle timer
    // ------------------------------------------------------------
    logic [1:0]               supply_sync_ff;
    logic [RELEASE_CNT_W-1:0] settle_cnt_ff;
    logic                     supply_settled_ff;
    logic                     supply_ok;

    assign supply_ok = supply_sync_ff[1];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            supply_sync_ff <= 2'h0;
        end else begin
            supply_sync_ff <= {supply_sync_ff[0], companion_supply_3v3};
        end
    end

    // any dip of the rail restarts the full settle time
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            settle_cnt_ff     <= '0;
            supply_settled_ff <= 1'b0;
        end else if (!supply_ok) begin
            settle_cnt_ff     <= '0;
            supply_settled_ff <= 1'b0;
        end else if (settle_cnt_ff != RELEASE_CNT_W'(RELEASE_CYC)) begin
            settle_cnt_ff     <= settle_cnt_ff + RELEASE_CNT_W'(1); // RQ4
            supply_settled_ff <= 1'b0;
        end else begin
            supply_settled_ff <= 1'b1; // RQ4
        end
    end

    // ------------------------------------------------------------
    // flash ownership and companion reset
    // ------------------------------------------------------------
    logic cfg_done_ff;

    // sticky: once our own load is over the flash is handed on for good
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfg_done_ff <= 1'b0;
        end else if (cfg_load_done) begin
            cfg_done_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            flash_companion_grant <= 1'b0;
        end else begin
            flash_companion_grant <= cfg_done_ff; // RQ1
        end
    end

    logic nxt_reset_release;

    // supply term is ANDed in directly so a dead rail always forces reset
    assign nxt_reset_release = cfg_done_ff                                    // RQ2
                             & supply_settled_ff & supply_ok                  // RQ5
                             & (~host_release_mode | host_boot_done);         // RQ6

    // dedicated output 0: nothing else is muxed onto this pin
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            companion_reset_n <= 1'b0;
        end else begin
            companion_reset_n <= nxt_reset_release; // RQ3
        end
    end

    // ------------------------------------------------------------
    // port status capture
    // ------------------------------------------------------------
    cch_port_status_t status_ff;
    cch_port_status_t nxt_status;

    // with no connection only the attached bit (zero) is reported
    assign nxt_status = port_status.attached ? port_status : STATUS_RESET;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status_ff <= STATUS_RESET;
        end else begin
            status_ff <= nxt_status; // RQ8
        end
    end

    // ------------------------------------------------------------
    // status target port
    // ------------------------------------------------------------
    logic status_read;

    cch_i2c_target u_target (
        .core_clk (core_clk),
        .reset    (reset),
        .own_addr (STATUS_TARGET_ADDR),
        .scl_in   (status_scl_in),
        .sda_in   (status_sda_in),
        .tx_data  ({STATUS_PAD, status_ff}),
        .sda_oe   (status_sda_oe),
        .rd_done  (status_read)
    );

    // open drain: only ever pulls low
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status_sda_out <= 1'b0;
        end else begin
            status_sda_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // connection change interrupt
    // ------------------------------------------------------------
    logic status_change;

    assign status_change = (nxt_status != status_ff);

    // a change in the same cycle as a read wins, so no event is lost
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status_irq <= 1'b0;
        end else if (status_change) begin
            status_irq <= 1'b1; // RQ9
        end else if (status_read) begin
            status_irq <= 1'b0; // RQ12
        end
    end

    // ------------------------------------------------------------
    // sideband mux control
    // ------------------------------------------------------------
    cch_mux_ctrl_t nxt_mux;

    always_comb begin
        nxt_mux                             = MUX_RESET;
        nxt_mux.aux_orientation_select      = nxt_status.orientation_flipped;       // RQ10
        nxt_mux.lowspeed_orientation_select = nxt_status.orientation_flipped;       // RQ10
        nxt_mux.aux_path_enable             = nxt_status.dp_mode_event;             // RQ11
        nxt_mux.lowspeed_path_enable        = nxt_status.highspeed_link_mode_event; // RQ11
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mux_ctrl <= MUX_RESET;
        end else begin
            mux_ctrl <= nxt_mux;
        end
    end

endmodule

// ===== sim/cch_handoff_checker.sv
module cch_handoff_checker
    import cch_pkg::*;
(
    input wire logic                      core_clk,              // clock
    input wire logic                      reset,                 // reset
    input wire logic                      cfg_load_done,         // config read
    input wire logic                      host_release_mode,     // host gate
    input wire logic                      host_boot_done,        // booted
    input wire logic                      companion_supply_3v3,  // rail good
    input wire cch_pkg::cch_port_status_t port_status,           // events
    input wire logic                      status_scl_in,         // scl
    input wire logic                      status_sda_in,         // sda
    input wire logic                      status_sda_out,        // sda level
    input wire logic                      status_sda_oe,         // sda pull
    input wire logic                      companion_reset_n,     // output 0
    input wire logic                      flash_companion_grant, // grant
    input wire logic                      status_irq,            // irq
    input wire cch_pkg::cch_mux_ctrl_t    mux_ctrl               // mux
);
    import cch_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    logic             cfg_seen_ff;
    logic             scl_prev_ff;
    logic [12:0]      sup_cnt_ff;
    logic [6:0]       scl_age_ff;
    cch_port_status_t filt_ff;

    function automatic cch_port_status_t filt(cch_port_status_t s);
        return s.attached ? s : STATUS_RESET;
    endfunction

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfg_seen_ff <= 1'b0;
            scl_prev_ff <= 1'b1;
            sup_cnt_ff  <= '0;
            scl_age_ff  <= '1;
            filt_ff     <= STATUS_RESET;
        end else begin
            cfg_seen_ff <= cfg_seen_ff | cfg_load_done;
            scl_prev_ff <= status_scl_in;
            // saturating, so a long-held rail never wraps
            sup_cnt_ff  <= !companion_supply_3v3 ? '0 : sup_cnt_ff + 13'(sup_cnt_ff != '1);
            scl_age_ff  <= (status_scl_in && !scl_prev_ff) ? '0
                         : scl_age_ff + 7'(scl_age_ff != '1);
            filt_ff     <= filt(port_status);
        end
    end

    reset_hold_a: assert property (!cfg_seen_ff |-> !companion_reset_n)
        else $error("reset released before config");
    grant_delay_a: assert property (
        cfg_load_done && !cfg_seen_ff |-> ##[2:3] flash_companion_grant)
        else $error("flash grant late");
    supply_gate_a: assert property (!companion_supply_3v3 [*5] |-> !companion_reset_n)
        else $error("reset released with rail down");
    release_wait_a: assert property (
        $rose(companion_reset_n) |-> sup_cnt_ff >= 13'(RELEASE_CYC + 2))
        else $error("reset released too soon");
    host_gate_a: assert property (
        (host_release_mode && !host_boot_done) [*2] |-> !companion_reset_n)
        else $error("reset released before boot");
    orient_follow_a: assert property (
        port_status[0] |=> mux_ctrl[3:2] == {2{$past(port_status[1])}})
        else $error("orientation selects wrong");
    path_enable_a: assert property (
        port_status[0] |=> mux_ctrl[1:0] == $past({port_status[2], port_status[3]}))
        else $error("path enables wrong");
    mux_idle_a: assert property (!port_status[0] |=> mux_ctrl == MUX_RESET)
        else $error("mux active while detached");
    irq_raise_a: assert property (filt(port_status) != filt_ff |=> status_irq)
        else $error("no irq on change");
    irq_hold_a: assert property ($fell(status_irq) |-> scl_age_ff < 7'h28)
        else $error("irq cleared without a read");
    sda_change_a: assert property ($rose(status_sda_oe) |-> !status_scl_in)
        else $error("sda pulled while scl high");

    cover property ($rose(companion_reset_n));
    cover property ($fell(status_irq));
    cover property ($rose(status_sda_oe));
endmodule

bind cch_handoff cch_handoff_checker u_chk (
    .core_clk              (core_clk),
    .reset                 (reset),
    .cfg_load_done         (cfg_load_done),
    .host_release_mode     (host_release_mode),
    .host_boot_done        (host_boot_done),
    .companion_supply_3v3  (companion_supply_3v3),
    .port_status           (port_status),
    .status_scl_in         (status_scl_in),
    .status_sda_in         (status_sda_in),
    .status_sda_out        (status_sda_out),
    .status_sda_oe         (status_sda_oe),
    .companion_reset_n     (companion_reset_n),
    .flash_companion_grant (flash_companion_grant),
    .status_irq            (status_irq),
    .mux_ctrl              (mux_ctrl)
);

// ===== sim/cch_companion_model.sv
module cch_companion_model #(
    parameter int HALF = 20 // core cycles per scl half period
) (
    input  wire logic core_clk, // core clock
    input  wire logic sda_line, // resolved sda level
    output logic      scl,      // scl, idles high
    output logic      sda_low   // pulls sda low when high
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // data held 2 cycles past scl fall, so no false start or stop
    task automatic clk_bit(input logic b, output logic s);
        sda_low <= ~b;
        wt(HALF);
        scl <= 1'b1;
        wt(HALF / 2);
        s = sda_line;
        wt(HALF / 2);
        scl <= 1'b0;
        wt(2);
    endtask

    // read one status byte after an interrupt, then nack and stop
    task automatic read_byte(input logic [6:0] addr, output logic ack,
                             output logic [7:0] data);
        logic       s;
        logic [7:0] b;
        b = {addr, 1'b1};
        sda_low <= 1'b1;
        wt(HALF);
        scl <= 1'b0;
        wt(2);
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            data[i] = s;
        end
        clk_bit(1'b1, s);
        sda_low <= 1'b1;
        wt(HALF);
        scl <= 1'b1;
        wt(HALF);
        sda_low <= 1'b0;
        wt(HALF);
    endtask

    // one written byte, which the target only acknowledges, then stop
    task automatic write_byte(input logic [6:0] addr, input logic [7:0] wd,
                              output logic ack);
        logic       s;
        logic [7:0] b;
        b = {addr, 1'b0};
        sda_low <= 1'b1;
        wt(HALF);
        scl <= 1'b0;
        wt(2);
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
        for (int i = 7; i >= 0; i--) clk_bit(wd[i], s);
        clk_bit(1'b1, s);
        ack = ack & ~s;
        sda_low <= 1'b1;
        wt(HALF);
        scl <= 1'b1;
        wt(HALF);
        sda_low <= 1'b0;
        wt(HALF);
    endtask
endmodule

// ===== sim/cch_handoff_tb.sv
module cch_handoff_tb
    import cch_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic             core_clk = 1'b0;
    logic             reset = 1'b1;
    logic             cfg_load_done = 1'b0;
    logic             host_release_mode = 1'b0;
    logic             host_boot_done = 1'b0;
    logic             supply = 1'b1;
    cch_port_status_t port_status = STATUS_RESET;
    logic             scl, sda_low, sda_line, sda_out, sda_oe, reset_n, grant, irq;
    cch_mux_ctrl_t    mux;
    int               error_cnt = 0;
    int               n_tests = 0;

    always #12.5 core_clk = ~core_clk;
    // open drain with pull-up
    assign sda_line = ~(sda_oe | sda_low);

    cch_handoff dut (
        .core_clk(core_clk), .reset(reset), .cfg_load_done(cfg_load_done),
        .host_release_mode(host_release_mode), .host_boot_done(host_boot_done),
        .companion_supply_3v3(supply), .port_status(port_status),
        .status_scl_in(scl), .status_sda_in(sda_line), .status_sda_out(sda_out),
        .status_sda_oe(sda_oe), .companion_reset_n(reset_n),
        .flash_companion_grant(grant), .status_irq(irq), .mux_ctrl(mux)
    );
    cch_companion_model #(.HALF(20)) comp (
        .core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
    );

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s: got %b", $time, what, got);
        end
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_rel(input int lim, output int n);
        n = 0;
        while (reset_n !== 1'b1) begin
            if (n == lim) begin
                error_cnt++;
                $display("[ERR] %0t reset release timed out", $time);
                conclude();
            end
            wt(1);
            n++;
        end
    endtask

    task automatic s_cfg();
        int n;
        chk_bit(reset_n, 1'b0, "reset_n at reset");
        chk_val(8'(mux), 8'h00, "mux at reset");
        wt(4100);
        chk_bit(reset_n, 1'b0, "reset_n before config");
        chk_bit(grant, 1'b0, "grant before config");
        cfg_load_done <= 1'b1;
        wt(1);
        cfg_load_done <= 1'b0;
        wt(3);
        chk_bit(grant, 1'b1, "grant after config");
        wait_rel(8, n);
    endtask

    task automatic s_supply();
        int n;
        supply <= 1'b0;
        wt(6);
        chk_bit(reset_n, 1'b0, "reset_n with rail down");
        supply <= 1'b1;
        wt(2000);
        supply <= 1'b0; // short dip must restart the settle count
        wt(1);
        supply <= 1'b1;
        wait_rel(RELEASE_CYC + 10, n);
        chk_bit(n >= int'(RELEASE_CYC), 1'b1, "release too early");
        chk_bit(n <= int'(RELEASE_CYC) + 8, 1'b1, "release too late");
    endtask

    task automatic s_host();
        int n;
        host_release_mode <= 1'b1;
        wt(53);
        chk_bit(reset_n, 1'b0, "reset_n held for boot");
        host_boot_done <= 1'b1;
        wait_rel(8, n);
    endtask

    task automatic s_mux();
        logic [3:0] exp;
        for (int v = 0; v < 16; v++) begin
            port_status <= 4'(v);
            wt(3);
            exp = v[0] ? {v[1], v[1], v[2], v[3]} : 4'h0;
            chk_val(8'(mux), {4'h0, exp}, "mux lines");
        end
    endtask

    task automatic s_status();
        logic       ack;
        logic [7:0] d;
        port_status <= 4'hb;
        wt(200);
        chk_bit(irq, 1'b1, "irq held unread");
        comp.read_byte(7'h39, ack, d);
        chk_bit(ack, 1'b0, "foreign address acked");
        chk_bit(irq, 1'b1, "irq cleared by foreign read");
        comp.write_byte(7'h38, 8'h5a, ack);
        chk_bit(ack, 1'b1, "write not acked");
        chk_bit(irq, 1'b1, "irq cleared by write");
        comp.read_byte(7'h38, ack, d);
        chk_bit(ack, 1'b1, "own address acked");
        chk_val(d, 8'h0b, "status byte");
        chk_bit(irq, 1'b0, "irq after read");
        chk_bit(sda_out, 1'b0, "sda drive level");
        port_status <= 4'ha;
        wt(3);
        chk_bit(irq, 1'b1, "irq on detach");
        comp.read_byte(7'h38, ack, d);
        chk_val(d, 8'h00, "status when detached");
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        s_cfg();
        s_supply();
        s_host();
        s_mux();
        s_status();
        conclude();
    end
endmodule
